// File: design/plrm_paged_regs.v
// How it works
// - Two page bits select pages 0, 1, 2
// - Page0 01/02: read local address, write ring
// - Page0 04-06: tx status read, tx setup write
// - Page0 08/09: remote address read; 08-0B setup write
// - Page0 0C-0F: status/tallies read, config write
// - Boundary and irq status read/write at 03/07
// - Page1 01-07: station address, current page
// - Page1 08-0F: eight multicast hash bytes
// - Page2 01/02 read ring, write local address; 04 reads tx page
// - Page2 03/05/06/07 pointers and counters read/write
// - Page2 0C-0F read config; rest reserved
// - Sixteen-bit registers split into byte halves
// - Page registers hold address bits 15-8
// - Transmit start loads page, clears low byte
// - Transmit count is sixteen bits, lo/hi
// - No truncation of long transmissions
// - Ring registers supervise receive buffer ring
// - Next page equals boundary: abort, flag
// - Remote step two per word, one per byte
// - Current page initialised from ring start while stopped
`timescale 1ns/100ps
`default_nettype none
`include "plrm_defs.vh"

module plrm_paged_regs (
    input wire clk,
    input wire rst_b,
    input wire [3:0] register_offset,
    input wire rd_stb,
    input wire wr_stb,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data_r,
    output reg rd_valid_r,
    output reg fifo_pop_r,
    input wire [7:0] tx_status_in,
    input wire [7:0] collision_count_in,
    input wire [7:0] loopback_fifo_in,
    input wire [7:0] rx_status_in,
    input wire tally_frame_align_inc,
    input wire tally_bad_check_inc,
    input wire tally_missed_packet_inc,
    input wire [7:0] irq_event_in,
    input wire tx_start,
    input wire local_step,
    input wire link_req,
    input wire [7:0] link_next_page,
    input wire rx_commit,
    input wire remote_word_step,
    input wire remote_byte_step,
    output wire [7:0] command,
    output wire [7:0] rx_config,
    output wire [7:0] tx_config,
    output wire [7:0] data_config,
    output wire [7:0] irq_mask,
    output wire [7:0] irq_status,
    output wire [7:0] ring_start_page,
    output wire [7:0] ring_stop_page,
    output wire [7:0] boundary_page,
    output wire [7:0] receive_write_page,
    output wire [7:0] tx_page_start,
    output wire [15:0] tx_count,
    output wire [15:0] local_dma_addr,
    output wire [15:0] remote_dma_addr,
    output wire [15:0] remote_count_left,
    output wire [47:0] station_addr,
    output wire [63:0] mcast_hash,
    output reg link_abort_r
);

    // ************************************************************
    // State
    // ************************************************************
    reg [7:0] command_r;
    reg [7:0] rx_config_r;
    reg [7:0] tx_config_r;
    reg [7:0] data_config_r;
    reg [7:0] irq_mask_r;
    reg [7:0] irq_status_r;
    reg [7:0] irq_status_nxt;
    reg [7:0] ring_start_r;
    reg [7:0] ring_stop_r;
    reg [7:0] boundary_r;
    reg [7:0] receive_write_page_page_r;
    reg [7:0] tx_page_r;
    reg [7:0] tx_count_lo_r;
    reg [7:0] tx_count_hi_r;
    reg [15:0] local_addr_r;
    reg [7:0] remote_start_lo_r;
    reg [7:0] remote_start_hi_r;
    reg [15:0] remote_addr_r;
    reg [15:0] remote_count_r;
    reg [7:0] remote_next_ptr_r;
    reg [7:0] local_next_ptr_r;
    reg [7:0] addr_counter_high_r;
    reg [7:0] addr_counter_low_r;
    reg [7:0] tally_frame_align_r;
    reg [7:0] tally_bad_check_r;
    reg [7:0] tally_missed_packet_r;
    reg [7:0] station_r [0:5];
    reg [7:0] hash_r [0:7];
    reg [7:0] rd_mux;
    reg [7:0] wrap_page;
    reg [15:0] remote_step;
    wire [1:0] page;
    wire wr_p0;
    wire wr_p1;
    wire wr_p2;
    wire link_hit;

    assign page = {command_r[`PLRM_CMD_PAGE_HI],
                   command_r[`PLRM_CMD_PAGE_LO]};
    assign wr_p0 = wr_stb && (page == `PLRM_PAGE_0);
    assign wr_p1 = wr_stb && (page == `PLRM_PAGE_1);
    assign wr_p2 = wr_stb && (page == `PLRM_PAGE_2);

    // ************************************************************
    // Ring supervision
    // ************************************************************
    // wrap at ring stop
    always @* begin
        if (link_next_page == ring_stop_r) begin
            wrap_page = ring_start_r;
        end else begin
            wrap_page = link_next_page;
        end
    end

    assign link_hit = link_req && (wrap_page == boundary_r);

    always @* begin
        if (remote_word_step) begin
            remote_step = `PLRM_STEP_WORD;
        end else if (remote_byte_step) begin
            remote_step = `PLRM_STEP_BYTE;
        end else begin
            remote_step = `PLRM_WORD_RESET;
        end
    end

    // ************************************************************
    // Interrupt status: write one clears, event set wins
    // ************************************************************
    always @* begin
        irq_status_nxt = irq_status_r;
        if (wr_p0 && register_offset == `PLRM_OFS_07) begin
            irq_status_nxt = irq_status_nxt & ~wr_data;
        end
        irq_status_nxt = irq_status_nxt | irq_event_in;
        if (link_hit) begin
            irq_status_nxt[`PLRM_IRQ_OVERWRITE_BIT] = 1'b1;
        end
    end

    // ************************************************************
    // Control and pointer registers
    // ************************************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            command_r <= `PLRM_CMD_RESET;
            rx_config_r <= `PLRM_BYTE_RESET;
            tx_config_r <= `PLRM_BYTE_RESET;
            data_config_r <= `PLRM_BYTE_RESET;
            irq_mask_r <= `PLRM_BYTE_RESET;
            irq_status_r <= `PLRM_BYTE_RESET;
            ring_start_r <= `PLRM_BYTE_RESET;
            ring_stop_r <= `PLRM_BYTE_RESET;
            boundary_r <= `PLRM_BYTE_RESET;
            receive_write_page_page_r <= `PLRM_BYTE_RESET;
            tx_page_r <= `PLRM_BYTE_RESET;
            tx_count_lo_r <= `PLRM_BYTE_RESET;
            tx_count_hi_r <= `PLRM_BYTE_RESET;
            local_addr_r <= `PLRM_WORD_RESET;
            remote_start_lo_r <= `PLRM_BYTE_RESET;
            remote_start_hi_r <= `PLRM_BYTE_RESET;
            remote_addr_r <= `PLRM_WORD_RESET;
            remote_count_r <= `PLRM_WORD_RESET;
            remote_next_ptr_r <= `PLRM_BYTE_RESET;
            local_next_ptr_r <= `PLRM_BYTE_RESET;
            addr_counter_high_r <= `PLRM_BYTE_RESET;
            addr_counter_low_r <= `PLRM_BYTE_RESET;
            link_abort_r <= 1'b0;
        end else begin
            irq_status_r <= irq_status_nxt;
            link_abort_r <= link_hit;
            if (wr_stb && register_offset == `PLRM_OFS_COMMAND) begin
                command_r <= wr_data;
            end
            if (tx_start) begin
                local_addr_r <= {tx_page_r, 8'h00};
            end else if (link_req && !link_hit) begin
                local_addr_r <= {wrap_page, 8'h00};
            end else if (local_step) begin
                local_addr_r <= local_addr_r + `PLRM_STEP_BYTE;
            end
            if (rx_commit) begin
                receive_write_page_page_r <= local_addr_r[15:8];
            end
            if (remote_word_step || remote_byte_step) begin
                remote_addr_r <= remote_addr_r + remote_step;
                if (remote_count_r > remote_step) begin
                    remote_count_r <= remote_count_r - remote_step;
                end else begin
                    remote_count_r <= `PLRM_WORD_RESET;
                end
            end
            if (wr_p0) begin
                case (register_offset)
                    `PLRM_OFS_01: begin
                        ring_start_r <= wr_data;
                        if (command_r[`PLRM_CMD_STOP_BIT]) begin
                            receive_write_page_page_r <= wr_data;
                        end
                    end
                    `PLRM_OFS_02: ring_stop_r <= wr_data;
                    `PLRM_OFS_03: boundary_r <= wr_data;
                    `PLRM_OFS_04: tx_page_r <= wr_data;
                    `PLRM_OFS_05: tx_count_lo_r <= wr_data;
                    `PLRM_OFS_06: tx_count_hi_r <= wr_data;
                    `PLRM_OFS_08: begin
                        remote_start_lo_r <= wr_data;
                        remote_addr_r[7:0] <= wr_data;
                    end
                    `PLRM_OFS_09: begin
                        remote_start_hi_r <= wr_data;
                        remote_addr_r[15:8] <= wr_data;
                    end
                    `PLRM_OFS_0A: remote_count_r[7:0] <= wr_data;
                    `PLRM_OFS_0B: remote_count_r[15:8] <= wr_data;
                    `PLRM_OFS_0C: rx_config_r <= wr_data;
                    `PLRM_OFS_0D: tx_config_r <= wr_data;
                    `PLRM_OFS_0E: data_config_r <= wr_data;
                    `PLRM_OFS_0F: irq_mask_r <= wr_data;
                    default: begin
                    end
                endcase
            end
            if (wr_p1 && register_offset == `PLRM_OFS_07) begin
                receive_write_page_page_r <= wr_data;
            end
            if (wr_p2) begin
                case (register_offset)
                    `PLRM_OFS_01: local_addr_r[7:0] <= wr_data;
                    `PLRM_OFS_02: local_addr_r[15:8] <= wr_data;
                    `PLRM_OFS_03: remote_next_ptr_r <= wr_data;
                    `PLRM_OFS_05: local_next_ptr_r <= wr_data;
                    `PLRM_OFS_06: addr_counter_high_r <= wr_data;
                    `PLRM_OFS_07: addr_counter_low_r <= wr_data;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Tally counters, saturating
    // ************************************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tally_frame_align_r <= `PLRM_BYTE_RESET;
            tally_bad_check_r <= `PLRM_BYTE_RESET;
            tally_missed_packet_r <= `PLRM_BYTE_RESET;
        end else begin
            if (tally_frame_align_inc &&
                tally_frame_align_r != `PLRM_TALLY_MAX) begin
                tally_frame_align_r <= tally_frame_align_r + 8'h01;
            end
            if (tally_bad_check_inc &&
                tally_bad_check_r != `PLRM_TALLY_MAX) begin
                tally_bad_check_r <= tally_bad_check_r + 8'h01;
            end
            if (tally_missed_packet_inc &&
                tally_missed_packet_r != `PLRM_TALLY_MAX) begin
                tally_missed_packet_r <= tally_missed_packet_r + 8'h01;
            end
        end
    end

    // ************************************************************
    // Station address and multicast hash bytes
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_hash
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    hash_r[gi] <= `PLRM_BYTE_RESET;
                end else if (wr_p1 && register_offset ==
                             (`PLRM_OFS_08 + gi[3:0])) begin
                    hash_r[gi] <= wr_data;
                end
            end
            assign mcast_hash[gi*8 +: 8] = hash_r[gi];
            if (gi < 6) begin : g_station
                always @(posedge clk or negedge rst_b) begin
                    if (!rst_b) begin
                        station_r[gi] <= `PLRM_BYTE_RESET;
                    end else if (wr_p1 && register_offset ==
                                 (`PLRM_OFS_01 + gi[3:0])) begin
                        station_r[gi] <= wr_data;
                    end
                end
                assign station_addr[gi*8 +: 8] = station_r[gi];
            end
        end
    endgenerate

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    always @* begin
        rd_mux = `PLRM_BYTE_RESET;
        if (register_offset == `PLRM_OFS_COMMAND) begin
            rd_mux = command_r;
        end else begin
            case (page)
                `PLRM_PAGE_0: begin
                    case (register_offset)
                        `PLRM_OFS_01: rd_mux = local_addr_r[7:0];
                        `PLRM_OFS_02: rd_mux = local_addr_r[15:8];
                        `PLRM_OFS_03: rd_mux = boundary_r;
                        `PLRM_OFS_04: rd_mux = tx_status_in;
                        `PLRM_OFS_05: rd_mux = collision_count_in;
                        `PLRM_OFS_06: rd_mux = loopback_fifo_in;
                        `PLRM_OFS_07: rd_mux = irq_status_r;
                        `PLRM_OFS_08: rd_mux = remote_addr_r[7:0];
                        `PLRM_OFS_09: rd_mux = remote_addr_r[15:8];
                        `PLRM_OFS_0C: rd_mux = rx_status_in;
                        `PLRM_OFS_0D: rd_mux = tally_frame_align_r;
                        `PLRM_OFS_0E: rd_mux = tally_bad_check_r;
                        `PLRM_OFS_0F: rd_mux = tally_missed_packet_r;
                        default: rd_mux = `PLRM_BYTE_RESET;
                    endcase
                end
                `PLRM_PAGE_1: begin
                    if (register_offset >= `PLRM_OFS_08) begin
                        rd_mux = hash_r[register_offset[2:0]];
                    end else if (register_offset == `PLRM_OFS_07) begin
                        rd_mux = receive_write_page_page_r;
                    end else begin
                        rd_mux = station_r[register_offset[2:0] - 3'd1];
                    end
                end
                `PLRM_PAGE_2: begin
                    case (register_offset)
                        `PLRM_OFS_01: rd_mux = ring_start_r;
                        `PLRM_OFS_02: rd_mux = ring_stop_r;
                        `PLRM_OFS_03: rd_mux = remote_next_ptr_r;
                        `PLRM_OFS_04: rd_mux = tx_page_r;
                        `PLRM_OFS_05: rd_mux = local_next_ptr_r;
                        `PLRM_OFS_06: rd_mux = addr_counter_high_r;
                        `PLRM_OFS_07: rd_mux = addr_counter_low_r;
                        `PLRM_OFS_0C: rd_mux = rx_config_r;
                        `PLRM_OFS_0D: rd_mux = tx_config_r;
                        `PLRM_OFS_0E: rd_mux = data_config_r;
                        `PLRM_OFS_0F: rd_mux = irq_mask_r;
                        default: rd_mux = `PLRM_BYTE_RESET;
                    endcase
                end
                default: rd_mux = `PLRM_BYTE_RESET;
            endcase
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_r <= `PLRM_BYTE_RESET;
            rd_valid_r <= 1'b0;
            fifo_pop_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_stb;
            fifo_pop_r <= rd_stb && page == `PLRM_PAGE_0 &&
                          register_offset == `PLRM_OFS_06;
            if (rd_stb) begin
                rd_data_r <= rd_mux;
            end
        end
    end

    // ************************************************************
    // Outputs to the controller core
    // ************************************************************
    assign command = command_r;
    assign rx_config = rx_config_r;
    assign tx_config = tx_config_r;
    assign data_config = data_config_r;
    assign irq_mask = irq_mask_r;
    assign irq_status = irq_status_r;
    assign ring_start_page = ring_start_r;
    assign ring_stop_page = ring_stop_r;
    assign boundary_page = boundary_r;
    assign receive_write_page = receive_write_page_page_r;
    assign tx_page_start = tx_page_r;
    assign tx_count = {tx_count_hi_r, tx_count_lo_r};
    assign local_dma_addr = local_addr_r;
    assign remote_dma_addr = remote_addr_r;
    assign remote_count_left = remote_count_r;

endmodule

`default_nettype wire

// File: pkg/plrm_defs.vh
`ifndef PLRM_DEFS_VH
`define PLRM_DEFS_VH

// ****************************************************************
// Register offsets (low four address bits)
// ****************************************************************
`define PLRM_OFS_COMMAND 4'h0
`define PLRM_OFS_01 4'h1
`define PLRM_OFS_02 4'h2
`define PLRM_OFS_03 4'h3
`define PLRM_OFS_04 4'h4
`define PLRM_OFS_05 4'h5
`define PLRM_OFS_06 4'h6
`define PLRM_OFS_07 4'h7
`define PLRM_OFS_08 4'h8
`define PLRM_OFS_09 4'h9
`define PLRM_OFS_0A 4'ha
`define PLRM_OFS_0B 4'hb
`define PLRM_OFS_0C 4'hc
`define PLRM_OFS_0D 4'hd
`define PLRM_OFS_0E 4'he
`define PLRM_OFS_0F 4'hf

// ****************************************************************
// Page codes from {page_select_high, page_select_low}
// ****************************************************************
`define PLRM_PAGE_0 2'b00
`define PLRM_PAGE_1 2'b01
`define PLRM_PAGE_2 2'b10

// ****************************************************************
// Field positions
// ****************************************************************
`define PLRM_CMD_PAGE_HI 7
`define PLRM_CMD_PAGE_LO 6
`define PLRM_CMD_STOP_BIT 0
`define PLRM_IRQ_OVERWRITE_BIT 4

// ****************************************************************
// Reset values and steps
// ****************************************************************
`define PLRM_CMD_RESET 8'h21
`define PLRM_BYTE_RESET 8'h00
`define PLRM_WORD_RESET 16'h0000
`define PLRM_TALLY_MAX 8'hff
`define PLRM_STEP_WORD 16'h0002
`define PLRM_STEP_BYTE 16'h0001

`endif

// File: tb/plrm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module plrm_host_model (
    input wire logic clk,
    input wire logic [7:0] rd_data_r,
    input wire logic rd_valid_r,
    output logic [3:0] register_offset,
    output logic rd_stb,
    output logic wr_stb,
    output logic [7:0] wr_data
);
    initial begin
        register_offset = 4'h0;
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        wr_data = 8'h00;
    end
    task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
        @(negedge clk);
        register_offset = ofs;
        wr_data = d;
        wr_stb = 1'b1;
        @(negedge clk);
        wr_stb = 1'b0;
        wr_data = ~d;
    endtask
    task automatic rd(input logic [3:0] ofs, output logic [7:0] d);
        @(negedge clk);
        register_offset = ofs;
        rd_stb = 1'b1;
        @(negedge clk);
        rd_stb = 1'b0;
        d = rd_valid_r ? rd_data_r : 8'hxx;
    endtask
    task automatic page(input logic [1:0] p);
        wr(4'h0, {p[1], p[0] & ~p[1], 6'h21});
    endtask
endmodule
`default_nettype wire

// File: tb/plrm_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module plrm_regs_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] register_offset,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data_r,
    input wire logic rd_valid_r,
    input wire logic fifo_pop_r,
    input wire logic tx_start,
    input wire logic remote_word_step,
    input wire logic [7:0] command,
    input wire logic [7:0] irq_status,
    input wire logic [7:0] tx_page_start,
    input wire logic [15:0] tx_count,
    input wire logic [15:0] local_dma_addr,
    input wire logic [15:0] remote_dma_addr,
    input wire logic link_abort_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire [1:0] page_sel = command[7:6];
    wire p0_wr = wr_stb && page_sel == 2'b00;
    property p_rd_answer;
        rd_valid_r == $past(rd_stb);
    endproperty
    property p_cmd;
        wr_stb && register_offset == 4'h0 |=> command == $past(wr_data);
    endproperty
    property p_tx_start;
        tx_start && !wr_stb |=> local_dma_addr == {$past(tx_page_start), 8'h00};
    endproperty
    property p_res_rd;
        rd_stb && page_sel == 2'b10 && register_offset[3:2] == 2'b10
            |=> rd_data_r == 8'h00;
    endproperty
    property p_res_wr;
        wr_stb && page_sel == 2'b10 && register_offset == 4'h4
            |=> $stable(tx_page_start);
    endproperty
    property p_count;
        p0_wr && register_offset == 4'h6 |=> tx_count[15:8] == $past(wr_data);
    endproperty
    property p_remote;
        remote_word_step && !wr_stb
            |=> remote_dma_addr == $past(remote_dma_addr) + 16'h0002;
    endproperty
    property p_abort;
        link_abort_r |-> irq_status[4] ##1 !link_abort_r;
    endproperty
    property p_pop;
        rd_stb && page_sel == 2'b00 && register_offset == 4'h6 |=> fifo_pop_r;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read late");
    a_cmd: assert property (p_cmd) else $error("command not loaded");
    a_tx_start: assert property (p_tx_start) else $error("tx start");
    a_res_rd: assert property (p_res_rd) else $error("reserved read");
    a_res_wr: assert property (p_res_wr) else $error("reserved write");
    a_count: assert property (p_count) else $error("tx count high");
    a_remote: assert property (p_remote) else $error("remote step");
    a_abort: assert property (p_abort) else $error("abort flag");
    a_pop: assert property (p_pop) else $error("fifo pop");
    c_abort: cover property (link_abort_r);
    c_pop: cover property (fifo_pop_r);
    c_txs: cover property (tx_start && !wr_stb);
endmodule
bind plrm_paged_regs plrm_regs_sva u_sva (.clk, .rst_b, .register_offset,
    .rd_stb, .wr_stb, .wr_data, .rd_data_r, .rd_valid_r, .fifo_pop_r,
    .tx_start, .remote_word_step, .command, .irq_status, .tx_page_start,
    .tx_count, .local_dma_addr, .remote_dma_addr, .link_abort_r);
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] lv = 32'h0000_0000;
    logic [8:0] ev = 9'h000;
    logic [7:0] irq_ev = 8'h00;
    logic [7:0] nxt = 8'h00;
    logic [7:0] rv;
    logic [31:0] r;
    int n_mismatch = 0;
    int check_count = 0;
    wire [3:0] register_offset;
    wire rd_stb, wr_stb, rd_valid_r, link_abort_r;
    wire [7:0] wr_data, rd_data_r, irq_status;
    wire [15:0] tx_count, local_dma_addr, remote_count_left, remote_dma_addr;
    wire [7:0] command, rx_config, tx_config, data_config, irq_mask;
    wire [7:0] ring_start_page, ring_stop_page, boundary_page;
    wire [7:0] receive_write_page, tx_page_start;
    wire [47:0] station_addr;
    wire [63:0] mcast_hash;
    wire fifo_pop_r;
    // Write page, offset, data; read page, offset, expected
    logic [31:0] rows [24] = '{
        32'h035a_035a, 32'h1111_1111, 32'h1666_1666, 32'h1777_1777,
        32'h1880_1880, 32'h1f8f_1f8f, 32'h0140_2140, 32'h0260_2260,
        32'h0430_2430, 32'h0c0e_2c0e, 32'h0d02_2d02, 32'h0e49_2e49,
        32'h0f3f_2f3f, 32'h2333_2333, 32'h2555_2555, 32'h26a6_26a6,
        32'h27a7_27a7, 32'h21c4_01c4, 32'h22d5_02d5, 32'h2499_2430,
        32'h0812_0812, 32'h0934_0934, 32'h0a77_0a00, 32'h28ff_2800};
    plrm_host_model u_host (.clk(clk), .rd_data_r(rd_data_r),
        .rd_valid_r(rd_valid_r), .register_offset(register_offset),
        .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data));
    plrm_paged_regs u_dut (.clk(clk), .rst_b(rst_b),
        .register_offset(register_offset), .rd_stb(rd_stb), .wr_stb(wr_stb),
        .wr_data(wr_data), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .fifo_pop_r(fifo_pop_r), .tx_status_in(lv[7:0]),
        .collision_count_in(lv[15:8]), .loopback_fifo_in(lv[23:16]),
        .rx_status_in(lv[31:24]), .tally_frame_align_inc(ev[0]),
        .tally_bad_check_inc(ev[1]), .tally_missed_packet_inc(ev[2]),
        .irq_event_in(irq_ev), .tx_start(ev[3]), .local_step(ev[4]),
        .link_req(ev[5]), .link_next_page(nxt), .rx_commit(ev[6]),
        .remote_word_step(ev[7]), .remote_byte_step(ev[8]),
        .command(command), .rx_config(rx_config), .tx_config(tx_config),
        .data_config(data_config), .irq_mask(irq_mask),
        .irq_status(irq_status), .ring_start_page(ring_start_page),
        .ring_stop_page(ring_stop_page), .boundary_page(boundary_page),
        .receive_write_page(receive_write_page),
        .tx_page_start(tx_page_start),
        .tx_count(tx_count), .local_dma_addr(local_dma_addr),
        .remote_dma_addr(remote_dma_addr),
        .remote_count_left(remote_count_left),
        .station_addr(station_addr), .mcast_hash(mcast_hash),
        .link_abort_r(link_abort_r));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic pulse(input logic [8:0] m);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 9'h000;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        u_host.rd(4'h0, rv);
        chk(rv, 8'h21);
        for (int i = 0; i < 24; i++) begin
            r = rows[i];
            u_host.page(r[29:28]);
            u_host.wr(r[27:24], r[23:16]);
            u_host.page(r[13:12]);
            u_host.rd(r[11:8], rv);
            chk(rv, r[7:0]);
        end
        chk(station_addr[47:32], 16'h6600);
        chk({mcast_hash[63:56], mcast_hash[7:0]}, 16'h8f80);
        chk({ring_start_page, ring_stop_page}, 16'h4060);
        chk({boundary_page, tx_page_start}, 16'h5a30);
        chk({rx_config, tx_config}, 16'h0e02);
        chk({data_config, irq_mask}, 16'h493f);
        chk({command, receive_write_page}, 16'ha140);
        chk(remote_dma_addr, 16'h3412);
        u_host.page(2'b00);
        lv = 32'hc3b2_a190;
        for (int k = 0; k < 4; k++) begin
            u_host.rd(k == 3 ? 4'hc : 4'h4 + k[3:0], rv);
            chk(rv, lv[8*k +: 8]);
            chk(fifo_pop_r, k == 2);
        end
        repeat (3) pulse(9'h001);
        u_host.rd(4'hd, rv);
        chk(rv, 8'h03);
        pulse(9'h008);
        chk(local_dma_addr, 16'h3000);
        pulse(9'h040);
        u_host.wr(4'h5, 8'hdd);
        u_host.wr(4'h6, 8'h05);
        chk(tx_count, 16'h05dd);
        u_host.wr(4'ha, 8'h03);
        u_host.wr(4'hb, 8'h00);
        pulse(9'h080);
        pulse(9'h100);
        u_host.rd(4'h8, rv);
        chk(rv, 8'h15);
        chk(remote_count_left, 16'h0000);
        u_host.page(2'b01);
        u_host.rd(4'h7, rv);
        chk(rv, 8'h30);
        u_host.page(2'b00);
        nxt = 8'h60;
        pulse(9'h020);
        chk(link_abort_r, 1'b0);
        chk(local_dma_addr, 16'h4000);
        nxt = 8'h5a;
        pulse(9'h020);
        chk(link_abort_r, 1'b1);
        chk(local_dma_addr, 16'h4000);
        @(negedge clk);
        irq_ev = 8'h01;
        @(negedge clk);
        irq_ev = 8'h00;
        u_host.rd(4'h7, rv);
        chk(rv, 8'h11);
        u_host.wr(4'h7, 8'hff);
        u_host.rd(4'h7, rv);
        chk(rv, 8'h00);
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        chk(local_dma_addr, 16'h0000);
        u_host.rd(4'h0, rv);
        chk(rv, 8'h21);
        print_verdict;
    end
endmodule
`default_nettype wire
